// [rtl/lsa_top.sv]
// Operation
// - Short direct address is sign-extended
// - Low half maps low, high half high
// - Only address bits 23:0 decoded
// - No size given means 32-bit transfer
// - Word: first byte into bits 31:24
// - Half: first byte into bits 15:8
// - Unsigned short reads clear upper bits
// - Short writes truncate, source untouched
// - Zero extension fills zeros above
// - Sign extension replicates top bit
// - Signed values in two's complement
// - Indirect: base register plus signed offset
// - Offset range per instruction class
// - No-offset forms use zero offset
// - Predecrement, postincrement by access size
// - PC-relative: 14-bit offset from next
`default_nettype none
module lsa_top
  import lsa_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                reset_n_i,
  input  wire logic                ce_i,
  input  wire logic                req_valid_i,
  input  wire logic                req_write_i,
  input  wire logic [2:0]          req_mode_i,
  input  wire logic [2:0]          req_op_i,
  input  wire logic [2:0]          req_xsize_i,
  input  wire logic [31:0]         req_addr_i,
  input  wire logic [OFS_W-1:0]    req_offset_i,
  input  wire logic [31:0]         req_base_i,
  input  wire logic [31:0]         req_pc_next_i,
  input  wire logic [31:0]         req_store_i,
  input  wire logic                mem_ack_i,
  input  wire logic [7:0]          mem_rdata_i,
  output logic                     req_ready_o,
  output logic                     done_o,
  output logic                     ofs_err_o,
  output logic [31:0]              load_data_o,
  output logic [31:0]              ea_o,
  output logic                     base_we_o,
  output logic [31:0]              base_data_o,
  output logic                     mem_req_o,
  output logic                     mem_we_o,
  output logic [PHYS_AW-1:0]       mem_addr_o,
  output logic [7:0]               mem_wdata_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // Address calculation
  // ----------------------------------------------------------------
  lsa_ea_if ea_bus ();

  assign ea_bus.mode       = req_mode_i;
  assign ea_bus.op         = req_op_i;
  assign ea_bus.xsize      = req_xsize_i;
  assign ea_bus.addr_field = req_addr_i;
  assign ea_bus.offset     = req_offset_i;
  assign ea_bus.base       = req_base_i;
  assign ea_bus.pc_next    = req_pc_next_i;

  lsa_ea_calc u_calc (
    .bus (ea_bus.calc)
  );

  // ----------------------------------------------------------------
  // State and datapath registers
  // ----------------------------------------------------------------
  lsa_state_t  state;
  lsa_state_t  next_state;
  logic [31:0] ea_q;
  logic [2:0]  xs_q;
  logic [2:0]  nbytes;
  logic [1:0]  cnt;
  logic        upd_q;
  logic [31:0] sdata;
  logic [31:0] src_q;
  logic [31:0] acc;
  logic [31:0] base_new_q;
  logic [7:0]  first_byte;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic        req_take;
  logic        ack_take;
  logic        no_mem;
  logic        imm_done;
  logic        last_byte;
  logic        fin;
  logic        auto_step;
  logic [2:0]  nb_req;
  logic [31:0] store_align;
  logic [31:0] acc_next;
  logic [31:0] ind_sum;
  logic [31:0] pc_sum;

  // Request and byte handshakes, completion terms
  assign req_take  = ce_i && req_valid_i && req_ready_o && (state == ST_IDLE);
  assign ack_take  = ce_i && mem_ack_i && (state == ST_XFER);
  assign no_mem    = (req_op_i == EFFECTIVE_ADDRESS_LOAD_OP);
  assign imm_done  = req_take && (no_mem || !ea_bus.ofs_ok);
  assign last_byte = ({1'b0, cnt} == 3'(nbytes - 3'h1));
  assign fin       = ack_take && last_byte;
  assign auto_step = (req_mode_i == AM_PREDEC) || (req_mode_i == AM_POSTINC);
  assign nb_req    = lsa_nbytes(req_xsize_i);

  // Store data left-aligned, only the low bytes survive
  assign store_align = (nb_req == 3'h1) ? {req_store_i[7:0], 24'h00_0000}
                     : (nb_req == 3'h2) ? {req_store_i[15:0], 16'h0000}
                     : req_store_i;

  // Big-endian gather: earlier bytes move toward the top
  assign acc_next = {acc[23:0], mem_rdata_i};

  // Reference sums for checking
  assign ind_sum = req_base_i + {{(32-OFS_W){req_offset_i[OFS_W-1]}}, req_offset_i};
  assign pc_sum  = req_pc_next_i
                 + {{(32-OFS_W){req_offset_i[OFS_W-1]}}, req_offset_i};

  // Next state of the transfer sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (req_take && !no_mem && ea_bus.ofs_ok) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (fin) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // State, ready and completion strobes
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      ofs_err_o   <= 1'b0;
    end else if (ce_i) begin
      state       <= next_state;
      req_ready_o <= (next_state == ST_IDLE);
      done_o      <= imm_done || fin;
      ofs_err_o   <= req_take && !ea_bus.ofs_ok;
    end
  end

  // Captured request fields
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ea_q       <= WORD_RST;
      xs_q       <= SIZE_WORD;
      nbytes     <= 3'h4;
      upd_q      <= 1'b0;
      src_q      <= WORD_RST;
      base_new_q <= WORD_RST;
    end else if (req_take) begin
      ea_q       <= ea_bus.ea;
      xs_q       <= req_xsize_i;
      nbytes     <= nb_req;
      upd_q      <= auto_step;
      src_q      <= req_store_i;
      base_new_q <= ea_bus.base_new;
    end
  end

  // Byte counter and shift registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= CNT_RST;
      sdata      <= WORD_RST;
      acc        <= WORD_RST;
      first_byte <= 8'h00;
    end else if (req_take) begin
      cnt        <= CNT_RST;
      sdata      <= store_align;
      acc        <= WORD_RST;
    end else if (ack_take) begin
      cnt        <= 2'(cnt + 2'h1);
      sdata      <= {sdata[23:0], 8'h00};
      acc        <= acc_next;
      first_byte <= (cnt == CNT_RST) ? mem_rdata_i : first_byte;
    end
  end

  // ----------------------------------------------------------------
  // Memory side
  // ----------------------------------------------------------------
  // One byte per acknowledge, address steps upward
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= '0;
      mem_wdata_o <= 8'h00;
    end else if (ce_i) begin
      mem_req_o   <= (next_state == ST_XFER);
      mem_we_o    <= (req_take ? req_write_i : mem_we_o) && (next_state == ST_XFER);
      if (req_take) begin
        mem_addr_o  <= ea_bus.ea[PHYS_AW-1:0];
        mem_wdata_o <= store_align[31:24];
      end else if (ack_take) begin
        mem_addr_o  <= mem_addr_o + PHYS_AW'(1);
        mem_wdata_o <= sdata[23:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register side results
  // ----------------------------------------------------------------
  // Loaded value, computed address and base write-back
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      load_data_o <= WORD_RST;
      ea_o        <= WORD_RST;
      base_we_o   <= 1'b0;
      base_data_o <= WORD_RST;
    end else if (ce_i) begin
      base_we_o <= fin && upd_q;
      if (req_take) begin
        ea_o <= ea_bus.ea;
      end
      if (imm_done) begin
        load_data_o <= no_mem && ea_bus.ofs_ok ? ea_bus.ea : WORD_RST;
      end else if (fin && !mem_we_o) begin
        load_data_o <= lsa_extend(acc_next, xs_q);
      end
      if (fin) begin
        base_data_o <= base_new_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  sequence s_take_mem;
    req_take && !no_mem && ea_bus.ofs_ok;
  endsequence

  sequence s_last_ack;
    ack_take && last_byte;
  endsequence

  AST_DIR16_SEXT: assert property (
    req_take && req_mode_i == AM_DIR16
    |=> ea_o[31:16] == {16{$past(req_addr_i[15])}})
    else $error("short direct address not sign-extended");

  AST_DIR16_LOW: assert property (
    req_take && req_mode_i == AM_DIR16 && !req_addr_i[15]
    |=> ea_o[31:15] == 17'h0_0000)
    else $error("low short address left the low block");

  AST_PHYS_ADDR: assert property (
    mem_req_o |-> mem_addr_o == PHYS_AW'(ea_q[PHYS_AW-1:0] + {30'h0, cnt}))
    else $error("memory address does not follow effective address");

  AST_WORD_DEFAULT: assert property (
    s_take_mem ##0 req_xsize_i == SIZE_WORD |=> nbytes == 3'h4)
    else $error("default size is not four bytes");

  AST_WORD_ORDER: assert property (
    done_o && $past(fin) && !$past(mem_we_o) && xs_q == SIZE_WORD
    |-> load_data_o[31:24] == first_byte)
    else $error("first byte not in top of word");

  AST_HALF_ORDER: assert property (
    done_o && $past(fin) && !$past(mem_we_o) && nbytes == 3'h2
    |-> load_data_o[15:8] == first_byte)
    else $error("first byte not in bits 15:8 of half");

  AST_BYTE_ZERO: assert property (
    done_o && $past(fin) && !$past(mem_we_o) && xs_q == SIZE_BYTE_ZERO_EXT
    |-> load_data_o[31:8] == 24'h00_0000)
    else $error("unsigned byte read left upper bits set");

  AST_BYTE_SIGN: assert property (
    done_o && $past(fin) && !$past(mem_we_o) && xs_q == SIZE_BYTE_SIGN_EXT
    |-> load_data_o[31:8] == {24{load_data_o[7]}})
    else $error("signed byte read not sign-extended");

  AST_STORE_TRUNC: assert property (
    mem_req_o && mem_we_o && nbytes == 3'h1 |-> mem_wdata_o == src_q[7:0])
    else $error("byte store did not use low source byte");

  AST_IND_SUM: assert property (
    req_take && req_mode_i == AM_IND |=> ea_o == $past(ind_sum))
    else $error("indirect address is not base plus offset");

  AST_NOOFS: assert property (
    req_take && req_mode_i == AM_IND_NOOFS |=> ea_o == $past(req_base_i))
    else $error("no-offset form used a nonzero offset");

  AST_PCREL: assert property (
    req_take && req_mode_i == AM_PCREL |=> ea_o == $past(pc_sum))
    else $error("pc-relative address wrong");

  AST_SHORT_RANGE: assert property (
    req_take && req_mode_i == AM_IND && req_op_i == LOAD_STORE_OP
    && req_offset_i[13:12] == 2'b01 |=> done_o && ofs_err_o)
    else $error("out-of-range short offset accepted");

  AST_FINISH: assert property (
    s_last_ack ##0 upd_q |=> done_o && base_we_o && !mem_req_o
    && base_data_o == base_new_q)
    else $error("base not written back at end of access");

endmodule : lsa_top
`default_nettype wire

// [rtl/lsa_pkg.sv]
`default_nettype none
package lsa_pkg;

  // ----------------------------------------------------------------
  // Widths and limits
  // ----------------------------------------------------------------
  localparam int OFS_W         = 14;    // Widest offset field
  localparam int DIR16_W       = 16;    // Short direct address field
  localparam int PHYS_AW       = 24;    // Decoded physical address bits
  localparam int SHORT_OFS_MIN = -4096;
  localparam int SHORT_OFS_MAX = 4095;
  localparam int LONG_OFS_MIN  = -8192;
  localparam int LONG_OFS_MAX  = 8191;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operand addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AM_DIR16     = 3'b000,
    AM_DIR32     = 3'b001,
    AM_IND       = 3'b010,
    AM_IND_NOOFS = 3'b011,
    AM_PREDEC    = 3'b100,
    AM_POSTINC   = 3'b101,
    AM_PCREL     = 3'b110
  } lsa_mode_t;

  // Access size with extension kind; word is the no-suffix default
  typedef enum logic [2:0] {
    SIZE_WORD          = 3'b000,
    SIZE_HALF_ZERO_EXT = 3'b010,
    SIZE_HALF_SIGN_EXT = 3'b011,
    SIZE_BYTE_ZERO_EXT = 3'b100,
    SIZE_BYTE_SIGN_EXT = 3'b101
  } lsa_xsize_t;

  // Instruction class, selects the offset range
  typedef enum logic [2:0] {
    LOAD_STORE_OP             = 3'b000,
    CLEAR_OP                  = 3'b001,
    COMPARE_ZERO_OP           = 3'b010,
    COMPARE_ZERO_CARRY_OP     = 3'b011,
    INCREMENT_OP              = 3'b100,
    DECREMENT_OP              = 3'b101,
    EFFECTIVE_ADDRESS_LOAD_OP = 3'b110,
    OTHER_OP                  = 3'b111
  } lsa_op_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } lsa_state_t;

  // Bytes moved for a size code
  function automatic logic [2:0] lsa_nbytes(input logic [2:0] xs);
    unique case (xs)
      SIZE_BYTE_ZERO_EXT, SIZE_BYTE_SIGN_EXT: lsa_nbytes = 3'h1;
      SIZE_HALF_ZERO_EXT, SIZE_HALF_SIGN_EXT: lsa_nbytes = 3'h2;
      default:                                lsa_nbytes = 3'h4;
    endcase
  endfunction : lsa_nbytes

  // Widen a right-justified short read to 32 bits
  function automatic logic [31:0] lsa_extend(input logic [31:0] raw,
                                             input logic [2:0]  xs);
    unique case (xs)
      SIZE_BYTE_ZERO_EXT: lsa_extend = {24'h00_0000, raw[7:0]};
      SIZE_BYTE_SIGN_EXT: lsa_extend = {{24{raw[7]}}, raw[7:0]};
      SIZE_HALF_ZERO_EXT: lsa_extend = {16'h0000, raw[15:0]};
      SIZE_HALF_SIGN_EXT: lsa_extend = {{16{raw[15]}}, raw[15:0]};
      default:            lsa_extend = raw;
    endcase
  endfunction : lsa_extend

endpackage : lsa_pkg
`default_nettype wire

// [rtl/lsa_ea_if.sv]
`default_nettype none
interface lsa_ea_if;
  import lsa_pkg::*;

  logic [2:0]       mode;
  logic [2:0]       op;
  logic [2:0]       xsize;
  logic [31:0]      addr_field;
  logic [OFS_W-1:0] offset;
  logic [31:0]      base;
  logic [31:0]      pc_next;
  logic [31:0]      ea;
  logic [31:0]      base_new;
  logic             ofs_ok;

  modport calc (
    input  mode, op, xsize, addr_field, offset, base, pc_next,
    output ea, base_new, ofs_ok
  );
  modport user (
    output mode, op, xsize, addr_field, offset, base, pc_next,
    input  ea, base_new, ofs_ok
  );
endinterface : lsa_ea_if
`default_nettype wire

// [rtl/lsa_ea_calc.sv]
`default_nettype none
module lsa_ea_calc
  import lsa_pkg::*;
(
  lsa_ea_if.calc bus
);

  // ----------------------------------------------------------------
  // Offset decode
  // ----------------------------------------------------------------
  logic signed [OFS_W-1:0] ofs_s;
  logic        [31:0]      ofs32;
  logic        [31:0]      ofs_used;
  logic        [31:0]      step;
  logic                    short_class;
  logic                    short_ok;

  // Sign-extended offset, zero for forms without a field
  assign ofs_s    = bus.offset;
  assign ofs32    = {{(32-OFS_W){bus.offset[OFS_W-1]}}, bus.offset};
  assign ofs_used = (bus.mode == AM_IND || bus.mode == AM_PCREL) ? ofs32
                  : 32'h0000_0000;
  assign step     = {29'h0, lsa_nbytes(bus.xsize)};

  // Narrow range for the simple one-operand class
  assign short_class = (bus.op inside {LOAD_STORE_OP, CLEAR_OP, COMPARE_ZERO_OP,
                        COMPARE_ZERO_CARRY_OP, INCREMENT_OP, DECREMENT_OP});
  assign short_ok    = (ofs_s >= SHORT_OFS_MIN) && (ofs_s <= SHORT_OFS_MAX);
  assign bus.ofs_ok  = !(bus.mode == AM_IND && short_class) || short_ok;

  // ----------------------------------------------------------------
  // Address forming, wraps modulo 2^32
  // ----------------------------------------------------------------
  always_comb begin
    unique case (bus.mode)
      AM_DIR16:
        bus.ea = {{(32-DIR16_W){bus.addr_field[DIR16_W-1]}},
                  bus.addr_field[DIR16_W-1:0]};
      AM_DIR32:     bus.ea = bus.addr_field;
      AM_PREDEC:    bus.ea = bus.base - step;
      AM_POSTINC:   bus.ea = bus.base;
      AM_PCREL:     bus.ea = bus.pc_next + ofs_used;
      default:      bus.ea = bus.base + ofs_used;
    endcase
  end

  // New base value for the auto-step forms
  always_comb begin
    unique case (bus.mode)
      AM_PREDEC:  bus.base_new = bus.base - step;
      AM_POSTINC: bus.base_new = bus.base + step;
      default:    bus.base_new = bus.base;
    endcase
  end

endmodule : lsa_ea_calc
`default_nettype wire

// [bench/lsa_mem_model.sv]
`default_nettype none
module lsa_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        slow_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [23:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic             mem_ack_o,
  output logic [7:0]       mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [bit [23:0]];
  integer     seed = 32'h1b40;
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 8'h00;
  end
  // Byte handshake, write lands on the ack edge, slow mode stalls
  always @(posedge mclk_i) begin
    if (mem_ack_o && mem_req_i && mem_we_i) mem[mem_addr_i] = mem_wdata_i;
    #2;
    if (mem_req_i && !(slow_i && ($random(seed) % 3 != 0))) begin
      mem_ack_o = 1'b1;
      mem_rdata_o = mem.exists(mem_addr_i) ? mem[mem_addr_i] : 8'h00;
    end else begin
      mem_ack_o = 1'b0;
      mem_rdata_o = ~mem_rdata_o; // Released bus does not hold
    end
  end
endmodule : lsa_mem_model
`default_nettype wire

// [bench/lsa_top_tb.sv]
`default_nettype none
module lsa_top_tb
  import lsa_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] data;
    logic [31:0] ea;
    logic [31:0] bd;
    logic        err;
    logic        bwe;
    logic        cd;
  } lsa_note_t;
  logic             mclk_i = 1'b0;
  logic             reset_n_i = 1'b0;
  logic             valid = 1'b0;
  logic             wr = 1'b0;
  logic             slow = 1'b0;
  logic             ce = 1'b1;
  logic [2:0]       mode = 3'h0;
  logic [2:0]       opc = 3'h0;
  logic [2:0]       xs = 3'h0;
  logic [31:0]      addr = 32'h0;
  logic [OFS_W-1:0] ofs = 14'h0;
  logic [31:0]      base = 32'h0;
  logic [31:0]      store = 32'h0;
  logic             rdy, done, oerr, bwe, mreq, mwe, ack;
  logic [31:0]      ldata, ea, bdata;
  logic [23:0]      maddr;
  logic [7:0]       mwdata, rdata;
  logic [15:0]      d16 [4] = '{16'h0000, 16'h7fff, 16'h8000, 16'hffff};
  logic [2:0]       sz [5] = '{SIZE_WORD, SIZE_HALF_ZERO_EXT, SIZE_HALF_SIGN_EXT,
                               SIZE_BYTE_ZERO_EXT, SIZE_BYTE_SIGN_EXT};
  lsa_note_t        q [$];
  lsa_note_t        mn;
  integer           seed = 32'h1b40;
  int               fail_count = 0;
  int               total_checks = 0;
  int               cyc = 0;

  // Clock
  always #25 mclk_i = ~mclk_i;

  // Clock enable, dropped at random while the slow memory runs
  always @(posedge mclk_i) begin
    #2;
    ce = !(slow && ($random(seed) % 4 == 0));
  end

  lsa_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .req_valid_i(valid),
    .req_write_i(wr), .req_mode_i(mode), .req_op_i(opc), .req_xsize_i(xs), .req_addr_i(addr),
    .req_offset_i(ofs), .req_base_i(base), .req_pc_next_i(~base), .req_store_i(store),
    .mem_ack_i(ack), .mem_rdata_i(rdata), .req_ready_o(rdy), .done_o(done),
    .ofs_err_o(oerr), .load_data_o(ldata), .ea_o(ea), .base_we_o(bwe),
    .base_data_o(bdata), .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr),
    .mem_wdata_o(mwdata));

  lsa_mem_model u_mem (.mclk_i(mclk_i), .slow_i(slow), .mem_req_i(mreq), .mem_we_i(mwe),
    .mem_addr_i(maddr), .mem_wdata_i(mwdata), .mem_ack_o(ack), .mem_rdata_o(rdata));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Completion watcher against the oldest note
  always @(posedge mclk_i) begin
    #1;
    // A done held through a frozen edge is not a new result
    if (done === 1'b1 && ce === 1'b1) begin
      if (q.size() == 0) begin
        chk("spare_done", 32'h1, 32'h0);
      end else begin
        mn = q.pop_front();
        if (mn.cd) chk("load_data", ldata, mn.data);
        if (!mn.err) chk("ea", ea, mn.ea);
        chk("ofs_err", {31'h0, oerr}, {31'h0, mn.err});
        chk("base_we", {31'h0, bwe}, {31'h0, mn.bwe});
        if (mn.bwe) chk("base_data", bdata, mn.bd);
      end
    end
  end

  // Cycle ceiling
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // One request: note, drive, hold until taken, check stored bytes
  task automatic go(input logic [2:0] md, op, x, input logic w,
                    input logic [31:0] ad, input logic [13:0] of, input logic [31:0] bs);
    lsa_note_t   n;
    logic [31:0] e, v, st;
    logic [2:0]  nb;
    int          so;
    logic        r;
    logic [7:0]  ex;
    nb = x[2] ? 3'h1 : x[1] ? 3'h2 : 3'h4;
    so = $signed(of);
    e = (md == AM_DIR16) ? {{16{ad[15]}}, ad[15:0]} : (md == AM_DIR32) ? ad :
        (md == AM_PREDEC) ? bs - nb : (md == AM_IND_NOOFS || md == AM_POSTINC) ? bs :
        ((md == AM_PCREL) ? ~bs : bs) + {{18{of[13]}}, of};
    v = $random(seed);
    st = $random(seed);
    for (int i = 0; i < 5; i++) u_mem.mem[e[23:0] + 24'(i)] = v[31 - 8 * (i % 4) -: 8];
    n.err = md == AM_IND && op < 3'h6 && (so < -4096 || so > 4095);
    n.ea = e;
    n.cd = !w;
    n.data = n.err ? 32'h0 : op == 3'h6 ? e : x[2] ? {{24{x[0] & v[31]}}, v[31:24]} :
             x[1] ? {{16{x[0] & v[31]}}, v[31:16]} : v;
    n.bwe = !n.err && (md == AM_PREDEC || md == AM_POSTINC);
    n.bd = (md == AM_PREDEC) ? e : bs + nb;
    q.push_back(n);
    mode = md;
    opc = op;
    xs = x;
    wr = w;
    addr = ad;
    ofs = of;
    base = bs;
    store = st;
    valid = 1'b1;
    do begin
      #1;
      r = rdy && ce;
      @(posedge mclk_i);
      #2;
    end while (r !== 1'b1);
    if (op != 3'h6) begin
      valid = 1'b0;
      while (q.size() != 0) @(posedge mclk_i);
      #2;
      for (int i = 0; i < 4 && w; i++) begin
        ex = i < nb ? st[8 * (nb - 1 - i) +: 8] : v[31 - 8 * i -: 8];
        chk("mem_byte", {24'h0, u_mem.mem[e[23:0] + 24'(i)]}, {24'h0, ex});
      end
    end
  endtask : go

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    #2;
    reset_n_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    #2;
    foreach (d16[i]) go(AM_DIR16, 3'h6, SIZE_WORD, 1'b0, {16'($random(seed)), d16[i]},
                        14'h0, 32'h0);
    for (int k = 0; k < 20; k++) begin
      slow = k[1];
      go(k[0] ? AM_IND : AM_DIR32, LOAD_STORE_OP, sz[k % 5], k[2], $random(seed),
         14'($random(seed) % 4096), $random(seed));
    end
    for (int k = 0; k < 8; k++) go(AM_IND, 3'(k), SIZE_BYTE_SIGN_EXT, 1'b0, 32'h0,
      k < 6 ? (k[0] ? 14'h2fff : 14'h1000) : (k[0] ? 14'h1fff : 14'h2000),
      $random(seed));
    go(AM_IND, LOAD_STORE_OP, SIZE_WORD, 1'b0, 32'h0, 14'h3000, $random(seed));
    go(AM_IND, CLEAR_OP, SIZE_WORD, 1'b1, 32'h0, 14'h0fff, $random(seed));
    for (int k = 0; k < 6; k++) go(k < 3 ? AM_PREDEC : AM_POSTINC, LOAD_STORE_OP,
      sz[k % 3 * 2], k[0], 32'h0, 14'h0, $random(seed));
    go(AM_IND_NOOFS, 3'h6, SIZE_WORD, 1'b0, 32'h0, 14'h1234, $random(seed));
    go(AM_PCREL, 3'h6, SIZE_WORD, 1'b0, 32'h0, 14'h2000, $random(seed));
    go(AM_PCREL, 3'h6, SIZE_WORD, 1'b0, 32'h0, 14'h1fff, 32'h0);
    go(AM_IND, 3'h6, SIZE_WORD, 1'b0, 32'h0, 14'h0100, 32'hffff_fff0);
    go(AM_IND, 3'h6, SIZE_WORD, 1'b0, 32'h0, 14'h3fe0, 32'h0000_0010);
    valid = 1'b0;
    repeat (5) @(posedge mclk_i);
    chk("pending_notes", q.size(), 32'h0);
    end_sim();
  end
endmodule : lsa_top_tb
`default_nettype wire
